// *** common/pin_remap_pkg.sv ***
// What this block does
// - Timer two clock from bits 6-0
// - Word one routes capture two and one
// - Word two routes capture four and three
// - Word three routes capture six and five
// - Word four routes capture eight and seven
// - Code zero ties input to ground
// - Code one selects first comparator output
// - Code 124 selects remappable input pin 124
// - Unimplemented bits read zero, ignore writes
// - Selector bits read/write, clear at reset
// - Many selectors may name one pin
package pin_remap_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int SEL_W     = 7;
  localparam int SEL_COUNT = 9;
  localparam int REG_COUNT = 5;
  localparam int PIN_COUNT = 125;

  // ****************************************
  // Register byte offsets and field positions
  // ****************************************
  localparam logic [11:0] TIMER_TWO_CLOCK_SOURCE_SELECT_OFFSET     = 12'h000;
  localparam logic [11:0] CAPTURE_ONE_TWO_SOURCE_SELECT_OFFSET     = 12'h004;
  localparam logic [11:0] CAPTURE_THREE_FOUR_SOURCE_SELECT_OFFSET  = 12'h008;
  localparam logic [11:0] CAPTURE_FIVE_SIX_SOURCE_SELECT_OFFSET    = 12'h00C;
  localparam logic [11:0] CAPTURE_SEVEN_EIGHT_SOURCE_SELECT_OFFSET = 12'h010;
  localparam int          LOW_FIELD_LSB  = 0;
  localparam int          HIGH_FIELD_LSB = 8;

  // ****************************************
  // Reset value and selector codes
  // ****************************************
  localparam logic [6:0]  SEL_RESET       = 7'h00;
  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [6:0]  CODE_GROUND     = 7'h00;
  localparam logic [6:0]  CODE_COMPARATOR = 7'h01;
  localparam logic [6:0]  CODE_LAST_PIN   = 7'h7C;

  // ****************************************
  // Bus carriers
  // ****************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

endpackage : pin_remap_pkg

// *** core/route_select.sv ***
`timescale 1ns/1ps
`default_nettype none

// Turns one seven-bit selector into one registered peripheral input.
module route_select #(
  parameter int PIN_COUNT = 125
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Source choice and synchronised sources
  input  wire logic [6:0]           code_in,
  input  wire logic                 comparator_in,
  input  wire logic [PIN_COUNT-1:0] pins_in,
  // Routed level
  output logic                      routed_out
);

  logic pin_pick;
  logic code_is_pin;

  // ****************************************
  // Source selection
  // ****************************************

  // Out-of-range codes never index the pin vector.
  assign code_is_pin = (code_in > pin_remap_pkg::CODE_COMPARATOR) && (code_in <= pin_remap_pkg::CODE_LAST_PIN)
                       && (int'(code_in) < PIN_COUNT);
  assign pin_pick    = code_is_pin ? pins_in[code_in] : 1'b0;

  // The routed level is registered so glitches from a selector change stay inside.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      routed_out <= 1'b0;
    end else if (code_in == pin_remap_pkg::CODE_GROUND) begin
      routed_out <= 1'b0;
    end else if (code_in == pin_remap_pkg::CODE_COMPARATOR) begin
      routed_out <= comparator_in;
    end else begin
      routed_out <= pin_pick;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_ground_tie_zero: assert property ((code_in == pin_remap_pkg::CODE_GROUND) |=> !routed_out)
    else $error("Ground code did not give a low input.");
  a_comparator_path: assert property ((code_in == pin_remap_pkg::CODE_COMPARATOR) |=> routed_out == $past(comparator_in))
    else $error("Comparator code did not follow the comparator.");
  a_last_pin_path: assert property ((code_in == pin_remap_pkg::CODE_LAST_PIN) |=> routed_out == $past(pins_in[124]))
    else $error("Code 124 did not follow pin 124.");
  a_high_code_ground: assert property ((code_in > pin_remap_pkg::CODE_LAST_PIN) |=> !routed_out)
    else $error("Code above 124 did not give a low input.");

endmodule : route_select

`default_nettype wire

// *** core/capture_timer_input_remap.sv ***
`timescale 1ns/1ps
`default_nettype none

// Routes remappable pins or the first comparator onto the timer two clock and eight capture inputs.
module capture_timer_input_remap #(
  parameter int PIN_COUNT = pin_remap_pkg::PIN_COUNT
) (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // Register bus
  input  wire pin_remap_pkg::apb_req_s apb_req_in,
  output pin_remap_pkg::apb_rsp_s      apb_rsp_out,
  // Sources
  input  wire logic [PIN_COUNT-1:0]    remappable_pin_n_in,
  input  wire logic                    first_comparator_output_in,
  // Routed peripheral inputs
  output logic                         timer_two_external_clock_out,
  output logic [7:0]                   capture_input_out
);

  localparam int SW = pin_remap_pkg::SEL_W;
  localparam int SC = pin_remap_pkg::SEL_COUNT;

  // ****************************************
  // Helpers
  // ****************************************

  // Word index of a byte address, or REG_COUNT when nothing lives there.
  function automatic logic [2:0] word_index(input logic [11:0] addr);
    logic [2:0] idx;
    idx = 3'(pin_remap_pkg::REG_COUNT);
    if ((addr[1:0] == 2'h0) && (addr[11:5] == 7'h00) && (int'(addr[4:2]) < pin_remap_pkg::REG_COUNT)) begin
      idx = addr[4:2];
    end
    return idx;
  endfunction : word_index

  // Read image of one register; bit 15, bit 7 and unused fields stay zero.
  function automatic logic [15:0] reg_word(input logic [2:0] idx, input logic [SC-1:0][SW-1:0] s);
    logic [15:0] w;
    w = pin_remap_pkg::REG_RESET;
    if (idx == 3'h0) begin
      w[pin_remap_pkg::LOW_FIELD_LSB +: SW] = s[0];
    end else if (int'(idx) < pin_remap_pkg::REG_COUNT) begin
      w[pin_remap_pkg::LOW_FIELD_LSB +: SW]  = s[2 * int'(idx) - 1];
      w[pin_remap_pkg::HIGH_FIELD_LSB +: SW] = s[2 * int'(idx)];
    end
    return w;
  endfunction : reg_word

  // ****************************************
  // State
  // ****************************************
  pin_remap_pkg::apb_rsp_s   rsp_r;
  logic [SC-1:0][SW-1:0]     sel_r;
  logic [PIN_COUNT-1:0]      pin_meta_r;
  logic [PIN_COUNT-1:0]      pin_sync_r;
  logic                      cmp_meta_r;
  logic                      cmp_sync_r;
  logic [SC-1:0]             routed;
  logic [2:0]                idx;
  logic                      hit;
  logic                      setup;
  logic                      wr_en;
  logic                      rd_done;

  // ****************************************
  // Bus decode
  // ****************************************

  // Address, direction and data are held by the master through the access phase.
  assign idx     = word_index(apb_req_in.paddr);
  assign hit     = int'(idx) < pin_remap_pkg::REG_COUNT;
  assign setup   = apb_req_in.psel && !apb_req_in.penable;
  assign wr_en   = apb_req_in.psel && apb_req_in.penable && rsp_r.pready && apb_req_in.pwrite && !rsp_r.pslverr;
  assign rd_done = apb_req_in.psel && apb_req_in.penable && rsp_r.pready && !apb_req_in.pwrite;

  // ****************************************
  // Bus answer
  // ****************************************

  // The answer is prepared at the setup edge so the access phase never waits.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= setup;
      if (setup) begin
        rsp_r.pslverr <= !hit;
        rsp_r.prdata  <= (hit && !apb_req_in.pwrite) ? {16'h0000, reg_word(idx, sel_r)} : 32'h0000_0000;
      end
    end
  end

  assign apb_rsp_out = rsp_r;

  // ****************************************
  // Selector registers
  // ****************************************

  // Only the seven-bit fields are stored, so writes to bits 15 and 7 vanish.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < SC; i++) begin
        sel_r[i] <= pin_remap_pkg::SEL_RESET;
      end
    end else if (wr_en) begin
      if (idx == 3'h0) begin
        if (apb_req_in.pstrb[0]) begin
          sel_r[0] <= apb_req_in.pwdata[pin_remap_pkg::LOW_FIELD_LSB +: SW];
        end
      end else begin
        if (apb_req_in.pstrb[0]) begin
          sel_r[2 * int'(idx) - 1] <= apb_req_in.pwdata[pin_remap_pkg::LOW_FIELD_LSB +: SW];
        end
        if (apb_req_in.pstrb[1]) begin
          sel_r[2 * int'(idx)] <= apb_req_in.pwdata[pin_remap_pkg::HIGH_FIELD_LSB +: SW];
        end
      end
    end
  end

  // ****************************************
  // Source synchronisers
  // ****************************************

  // Pins and the comparator are asynchronous, so each passes two flops first.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= remappable_pin_n_in;
      pin_sync_r <= pin_meta_r;
      cmp_meta_r <= first_comparator_output_in;
      cmp_sync_r <= cmp_meta_r;
    end
  end

  // ****************************************
  // Routing
  // ****************************************

  // shared pins
  // Every selector reads the whole pin vector, so any number may name one pin.
  for (genvar g = 0; g < SC; g++) begin : g_route
    route_select #(
      .PIN_COUNT (PIN_COUNT)
    ) u_route (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .code_in       (sel_r[g]),
      .comparator_in (cmp_sync_r),
      .pins_in       (pin_sync_r),
      .routed_out    (routed[g])
    );
  end

  // Selector 0 drives the timer clock; selectors 1 to 8 drive capture one to eight.
  assign timer_two_external_clock_out = routed[0];
  assign capture_input_out            = routed[SC-1:1];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // A write that lands on one register offset while the given byte-lane condition holds.
  sequence s_write_at(logic [11:0] off, logic lane);
    apb_req_in.psel && apb_req_in.penable && rsp_r.pready && apb_req_in.pwrite
      && (apb_req_in.paddr == off) && lane;
  endsequence

  // A read setup cycle on one register offset.
  sequence s_read_at(logic [11:0] off);
    setup && !apb_req_in.pwrite && (apb_req_in.paddr == off);
  endsequence

  // ****************************************
  // Field writes
  // ****************************************

  // Each selector takes its own seven bits from the landing write.
  a_timer_field_write: assert property (
    s_write_at(pin_remap_pkg::TIMER_TWO_CLOCK_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[0])
      |=> sel_r[0] == $past(apb_req_in.pwdata[6:0]))
    else $error("Timer two selector did not take the written value.");

  a_cap_one_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_ONE_TWO_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[0])
      |=> sel_r[1] == $past(apb_req_in.pwdata[6:0]))
    else $error("Capture one selector did not take bits 6 to 0.");

  a_cap_two_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_ONE_TWO_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[1])
      |=> sel_r[2] == $past(apb_req_in.pwdata[14:8]))
    else $error("Capture two selector did not take bits 14 to 8.");

  a_cap_three_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_THREE_FOUR_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[0])
      |=> sel_r[3] == $past(apb_req_in.pwdata[6:0]))
    else $error("Capture three selector did not take bits 6 to 0.");

  a_cap_four_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_THREE_FOUR_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[1])
      |=> sel_r[4] == $past(apb_req_in.pwdata[14:8]))
    else $error("Capture four selector did not take bits 14 to 8.");

  a_cap_five_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_FIVE_SIX_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[0])
      |=> sel_r[5] == $past(apb_req_in.pwdata[6:0]))
    else $error("Capture five selector did not take bits 6 to 0.");

  a_cap_six_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_FIVE_SIX_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[1])
      |=> sel_r[6] == $past(apb_req_in.pwdata[14:8]))
    else $error("Capture six selector did not take bits 14 to 8.");

  a_cap_seven_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_SEVEN_EIGHT_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[0])
      |=> sel_r[7] == $past(apb_req_in.pwdata[6:0]))
    else $error("Capture seven selector did not take bits 6 to 0.");

  a_cap_eight_write: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_SEVEN_EIGHT_SOURCE_SELECT_OFFSET, apb_req_in.pstrb[1])
      |=> sel_r[8] == $past(apb_req_in.pwdata[14:8]))
    else $error("Capture eight selector did not take bits 14 to 8.");

  // ****************************************
  // Byte lanes and unused bits
  // ****************************************

  // A lane left off keeps its field, and the timer word owns no capture field.
  a_lane_off_keeps: assert property (
    s_write_at(pin_remap_pkg::CAPTURE_ONE_TWO_SOURCE_SELECT_OFFSET, !apb_req_in.pstrb[0])
      |=> $stable(sel_r[1]))
    else $error("Capture one selector changed with its lane off.");

  a_timer_write_alone: assert property (
    s_write_at(pin_remap_pkg::TIMER_TWO_CLOCK_SOURCE_SELECT_OFFSET, 1'h1)
      |=> $stable(sel_r[SC-1:1]))
    else $error("A timer two write changed a capture selector.");

  a_unused_bits_zero: assert property (
    rd_done |-> (rsp_r.prdata[31:15] == 17'h00000) && !rsp_r.prdata[7])
    else $error("Unimplemented register bits read as one.");

  // ****************************************
  // Readback
  // ****************************************

  // Read data is rebuilt here field by field, not through the read-image function.
  a_read_timer_word: assert property (
    s_read_at(pin_remap_pkg::TIMER_TWO_CLOCK_SOURCE_SELECT_OFFSET)
      |=> rsp_r.prdata == {25'h0, $past(sel_r[0])})
    else $error("Timer two word did not read back its selector.");

  a_read_shows_state: assert property (
    s_read_at(pin_remap_pkg::CAPTURE_ONE_TWO_SOURCE_SELECT_OFFSET)
      |=> rsp_r.pready && rsp_r.prdata == {17'h0, $past(sel_r[2]), 1'h0, $past(sel_r[1])})
    else $error("Capture one and two word did not read back its selectors.");

  a_read_three_four: assert property (
    s_read_at(pin_remap_pkg::CAPTURE_THREE_FOUR_SOURCE_SELECT_OFFSET)
      |=> rsp_r.prdata == {17'h0, $past(sel_r[4]), 1'h0, $past(sel_r[3])})
    else $error("Capture three and four word did not read back its selectors.");

  a_read_five_six: assert property (
    s_read_at(pin_remap_pkg::CAPTURE_FIVE_SIX_SOURCE_SELECT_OFFSET)
      |=> rsp_r.prdata == {17'h0, $past(sel_r[6]), 1'h0, $past(sel_r[5])})
    else $error("Capture five and six word did not read back its selectors.");

  a_read_seven_eight: assert property (
    s_read_at(pin_remap_pkg::CAPTURE_SEVEN_EIGHT_SOURCE_SELECT_OFFSET)
      |=> rsp_r.prdata == {17'h0, $past(sel_r[8]), 1'h0, $past(sel_r[7])})
    else $error("Capture seven and eight word did not read back its selectors.");

  // ****************************************
  // Bus answer
  // ****************************************

  // Zero wait states: the access phase always finds pready high.
  a_ready_after_setup: assert property (
    setup |=> rsp_r.pready)
    else $error("The access phase did not see pready.");

  a_write_reads_zero: assert property (
    (setup && apb_req_in.pwrite) |=> (rsp_r.prdata == 32'h0000_0000))
    else $error("A write returned nonzero read data.");

  // Unmapped words answer with an error and never reach a selector.
  a_refused_answer: assert property (
    (setup && !hit) |=> rsp_r.pslverr && (rsp_r.prdata == 32'h0000_0000))
    else $error("An unmapped address was not refused.");

  a_refused_no_write: assert property (
    (apb_req_in.psel && apb_req_in.penable && rsp_r.pslverr) |=> $stable(sel_r))
    else $error("A refused access changed a selector.");

  // ****************************************
  // Reset
  // ****************************************

  // Reset clears the selectors, the bus answer and every routed input.
  a_reset_clears_sel: assert property (
    @(posedge clk_in) disable iff (1'b0) rst_in |=> (sel_r == '0) && !timer_two_external_clock_out)
    else $error("Selectors were not cleared by reset.");

  a_reset_quiet_bus: assert property (
    @(posedge clk_in) disable iff (1'b0) rst_in |=> (rsp_r == '0) && (capture_input_out == 8'h00))
    else $error("Reset left the bus answer or a capture input set.");

  // ****************************************
  // Sources and routing
  // ****************************************

  // The guard skips the two edges whose flops still hold reset values.
  a_cmp_two_flops: assert property (
    (!$past(rst_in) && !$past(rst_in, 2)) |-> (cmp_sync_r == $past(first_comparator_output_in, 2)))
    else $error("The comparator did not pass exactly two flops.");

  a_pin_two_flops: assert property (
    (!$past(rst_in) && !$past(rst_in, 2)) |-> (pin_sync_r == $past(remappable_pin_n_in, 2)))
    else $error("The pins did not pass exactly two flops.");

  a_cap_one_comparator: assert property (
    (sel_r[1] == pin_remap_pkg::CODE_COMPARATOR) |=> (capture_input_out[0] == $past(cmp_sync_r)))
    else $error("Capture one did not follow the comparator.");

  a_write_routes_out: assert property (
    (wr_en && idx == 3'h0 && apb_req_in.pstrb[0] && apb_req_in.pwdata[6:0] == 7'h00)
      |=> ##1 !timer_two_external_clock_out)
    else $error("Timer clock not grounded after selecting code zero.");

  for (genvar c = 1; c < SC; c++) begin : g_ground_check
    a_capture_ground: assert property (
      (sel_r[c] == pin_remap_pkg::CODE_GROUND) |=> !capture_input_out[c-1])
      else $error("A capture input was not grounded by code zero.");
  end

endmodule : capture_timer_input_remap

`default_nettype wire

// *** dv/pin_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Stands in for the pad ring and the comparator that feed the remap block.
module pin_source_model #(
  parameter int PIN_COUNT = 125
) (
  // Control
  input  wire logic            flip_in,
  // Sources
  output logic [PIN_COUNT-1:0] pins_out,
  output logic                 comparator_out
);
  // pins held input
  // Every third pin differs, so a selector off by one shows up as a wrong level when either pin is a multiple of three.
  always_comb begin
    for (int n = 0; n < PIN_COUNT; n++) begin
      pins_out[n] = flip_in ^ (n % 3 == 0);
    end
  end

  // comparator level source
  // The comparator runs opposite to most pins, which keeps it apart from them.
  assign comparator_out = ~flip_in;
endmodule : pin_source_model

`default_nettype wire

// *** dv/capture_timer_input_remap_test.sv ***
`timescale 1ns/1ps
`default_nettype none

// Drives the remap block over APB and checks readback and routed levels.
module capture_timer_input_remap_test;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] w;
    logic [15:0] r;
  } row_s;

  logic                    clk_in;
  logic                    rst_in;
  logic                    flip;
  pin_remap_pkg::apb_req_s req;
  pin_remap_pkg::apb_rsp_s rsp;
  logic [124:0]            pins;
  logic                    cmp;
  logic                    tmr;
  logic [7:0]              cap;
  logic [31:0]             rd;
  logic                    err;
  logic [3:0]              strb;
  int                      fails;
  int                      num_checks;
  logic [6:0]              sel [9] = '{7'h7C, 7'h01, 7'h00, 7'h02, 7'h7D, 7'h50, 7'h50, 7'h7F, 7'h0F};
  // ****************************************
  // Table rows: address, write data, readback
  // ****************************************
  row_s rows [10] = '{'{12'h000, 32'hFFFFFFFF, 16'h007F}, '{12'h004, 32'hFFFFFFFF, 16'h7F7F},
    '{12'h008, 32'hFFFFFFFF, 16'h7F7F}, '{12'h00C, 32'hFFFFFFFF, 16'h7F7F},
    '{12'h010, 32'hFFFFFFFF, 16'h7F7F}, '{12'h000, 32'h0000007C, 16'h007C},
    '{12'h004, 32'h00000001, 16'h0001}, '{12'h008, 32'h00007D02, 16'h7D02},
    '{12'h00C, 32'h00005050, 16'h5050}, '{12'h010, 32'h00000F7F, 16'h0F7F}};

  capture_timer_input_remap #(.PIN_COUNT(125)) i_dut (
    .clk_in                      (clk_in),
    .rst_in                      (rst_in),
    .apb_req_in                  (req),
    .apb_rsp_out                 (rsp),
    .remappable_pin_n_in         (pins),
    .first_comparator_output_in  (cmp),
    .timer_two_external_clock_out(tmr),
    .capture_input_out           (cap)
  );

  pin_source_model #(.PIN_COUNT(125)) i_src (
    .flip_in       (flip),
    .pins_out      (pins),
    .comparator_out(cmp)
  );

  // The clock runs at 25 MHz.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Counts every compare and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    int i;
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: w, pstrb: strb};
    @(posedge clk_in);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      final_report();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  // expected source
  // Worked out from the codes alone, never from the outputs.
  function automatic logic src(input logic [6:0] c, input logic f);
    if (c == 7'h00 || c > 7'h7C) return 1'b0;
    if (c == 7'h01) return ~f;
    return f ^ (c % 3 == 0);
  endfunction : src

  // Bit 0 is the timer clock, bit k the capture channel k.
  task automatic check_routes;
    logic [8:0] exp;
    for (int k = 0; k < 9; k++) exp[k] = src(sel[k], flip);
    check({23'h0, cap, tmr}, {23'h0, exp});
  endtask : check_routes

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_in = 1'b1;
    req = '0;
    flip = 1'b0;
    strb = 4'hF;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({23'h0, cap, tmr}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, 32'h0);
    end
    // Upper and middle bits are dropped on write and read back low.
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, {16'h0, rows[i].r});
    end
    repeat (4) @(posedge clk_in);
    check_routes();
    flip <= 1'b1;
    repeat (5) @(posedge clk_in);
    check_routes();
    // Only the high lane is enabled, so capture one keeps its code.
    strb <= 4'h2;
    apb(1'b1, 12'h004, 32'h00002B15);
    strb <= 4'hF;
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h00002B01);
    sel[2] = 7'h2B;
    // A write past the last register is refused and changes no selector.
    apb(1'b1, 12'h014, 32'hFFFFFFFF);
    check({31'h0, err}, 32'h1);
    // Code zero on the timer word grounds the timer clock.
    apb(1'b1, 12'h000, 32'h0);
    sel[0] = 7'h00;
    repeat (3) @(posedge clk_in);
    check_routes();
    // An address past the last register is refused.
    apb(1'b0, 12'h014, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // A second reset in mid-run clears every selector again.
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({23'h0, cap, tmr}, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h0);
    final_report();
  end
endmodule : capture_timer_input_remap_test

`default_nettype wire
